// ### corr_defines.vh
// Purpose: shared constants of the cascadable transversal correlator
// Assumes: 250 MHz system clock
// Notes: definitions only, no logic
`ifndef CORR_DEFINES_VH
`define CORR_DEFINES_VH

`define TAPS 32
`define DATA_W 16
`define ACC_W 36
`define OUT_W 24
`define TAP_AW 5
`define SHIFT_MAX 4'hc

// coefficient width select codes
`define CW_4 2'h0
`define CW_8 2'h1
`define CW_12 2'h2
`define CW_16 2'h3

// clock period and least sample periods per coefficient width, in ns
`define CLK_PERIOD_NS 4
`define SPACE_CW4_NS 100
`define SPACE_CW8_NS 200
`define SPACE_CW12_NS 304
`define SPACE_CW16_NS 400

// least spacing in clock cycles, rounded up
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SPACE_CW4_CYC `CYC_UP(`SPACE_CW4_NS)
`define SPACE_CW8_CYC `CYC_UP(`SPACE_CW8_NS)
`define SPACE_CW12_CYC `CYC_UP(`SPACE_CW12_NS)
`define SPACE_CW16_CYC `CYC_UP(`SPACE_CW16_NS)

`endif

// ### shift_round.v
// Purpose: select a rounded 24-bit window from the 36-bit sum
// Assumes: shift code above 12 behaves as 12
// Notes: combinational; the caller registers the result
`timescale 1ns/10ps
`include "corr_defines.vh"

module shift_round (
   input wire [35:0] acc_i,
   input wire [3:0] shift_i,
   output reg [23:0] win_o
);

   reg [3:0] sh;
   reg signed [36:0] bias;
   reg signed [36:0] sum;
   reg signed [36:0] shifted;

   // half an lsb is added before the arithmetic shift, so the window is
   // rounded and sign-extended in one step
   always @* begin
      sh = (shift_i > `SHIFT_MAX) ? `SHIFT_MAX : shift_i;
      bias = (sh == 4'h0) ? 37'sd0 : (37'sd1 <<< (sh - 4'h1));
      sum = $signed({acc_i[35], acc_i}) + bias;
      shifted = sum >>> sh;
      win_o = shifted[23:0];
   end

endmodule

// ### transversal_correlator.v
// Purpose: 32-tap cascadable transversal correlator / convolver datapath
// Assumes: pin-side sample strobe and data, cascade input come from
//    outside the clock domain; host ports are on sys_clk_i
// Notes: host ports stand in for the memory-mapped interface
// How it works
// - 32 multiply stages feeding delay-and-add chain
// - two coefficient banks, one active, one host-side
// - writing bank swap exchanges the bank roles
// - continuous mode alternates banks every sample
// - 16-bit data, coefficients 4/8/12/16 bits
// - sample rate limited by coefficient width
// - full 36-bit accumulation, no rounding inside
// - barrel shifter picks rounded 24-bit window
// - 32-stage cascade register plus 24-bit adder
// - cascade input delayed 32 samples before add
// - samples and results also reachable by host
// - control and status visible to host
`timescale 1ns/10ps
`include "corr_defines.vh"

module transversal_correlator (
   input wire sys_clk_i,
   input wire rst_i,
   // dedicated sample and cascade pins
   input wire [15:0] pin_sample_i,
   input wire pin_strobe_i,
   input wire [23:0] casc_in_i,
   // host side: samples and results
   input wire [15:0] host_sample_i,
   input wire host_sample_wr_i,
   input wire host_result_rd_i,
   // host side: coefficient access to the inactive bank
   input wire [4:0] coef_addr_i,
   input wire [15:0] coef_wdata_i,
   input wire coef_wr_i,
   input wire coef_rd_i,
   output reg [15:0] coef_rdata_o,
   // control
   input wire bank_swap_i,
   input wire cont_swap_i,
   input wire [1:0] coef_width_i,
   input wire [3:0] shift_i,
   input wire overrun_clr_i,
   // results and status
   output reg [23:0] result_o,
   output reg result_valid_o,
   output reg result_ready_o,
   output reg active_bank_o,
   output reg swap_pending_o,
   output reg overrun_o
);

   integer i;
   integer k_bank, k_part, k_line;

   // sign-extend the low bits of a coefficient to the chosen width
   function [15:0] coef_ext;
      input [15:0] c;
      input [1:0] w;
      begin
         case (w)
            `CW_4: coef_ext = {{12{c[3]}}, c[3:0]};
            `CW_8: coef_ext = {{8{c[7]}}, c[7:0]};
            `CW_12: coef_ext = {{4{c[11]}}, c[11:0]};
            default: coef_ext = c;
         endcase
      end
   endfunction

   // full-precision product, widened to the accumulator width
   function [35:0] mac_term;
      input [15:0] x;
      input [15:0] c;
      reg signed [31:0] p;
      begin
         p = $signed(x) * $signed(c);
         mac_term = {{4{p[31]}}, p};
      end
   endfunction

   // least spacing between samples for a coefficient width
   function [7:0] min_space;
      input [1:0] w;
      integer n;
      begin
         case (w)
            `CW_4: n = `SPACE_CW4_CYC;
            `CW_8: n = `SPACE_CW8_CYC;
            `CW_12: n = `SPACE_CW12_CYC;
            default: n = `SPACE_CW16_CYC;
         endcase
         min_space = n[7:0];
      end
   endfunction

   reg [15:0] bank0 [0:31];
   reg [15:0] bank1 [0:31];
   reg [35:0] part [0:31];
   reg [23:0] casc [0:31];
   reg [15:0] samp_s1;
   reg [15:0] samp_s2;
   reg strobe_s1;
   reg strobe_s2;
   reg strobe_s3;
   reg [23:0] casc_s1;
   reg [23:0] casc_s2;
   reg [23:0] casc_tail;
   reg calc;
   reg [7:0] gap_cnt;
   reg pin_evt;
   reg samp_evt;
   reg [15:0] samp_x;
   reg [15:0] act_coef [0:31];
   wire [23:0] scaled;

   // two flip-flops on every pin input before any logic reads it
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         samp_s1 <= 16'h0000;
         samp_s2 <= 16'h0000;
         strobe_s1 <= 1'b0;
         strobe_s2 <= 1'b0;
         strobe_s3 <= 1'b0;
         casc_s1 <= 24'h000000;
         casc_s2 <= 24'h000000;
      end else begin
         samp_s1 <= pin_sample_i;
         samp_s2 <= samp_s1;
         strobe_s1 <= pin_strobe_i;
         strobe_s2 <= strobe_s1;
         strobe_s3 <= strobe_s2;
         casc_s1 <= casc_in_i;
         casc_s2 <= casc_s1;
      end
   end

   // one sample event per strobe edge or host write; the host write wins
   // if both land together, the pin sample is then dropped
   always @* begin
      pin_evt = strobe_s2 & ~strobe_s3;
      samp_evt = pin_evt | host_sample_wr_i;
      samp_x = host_sample_wr_i ? host_sample_i : samp_s2;
      for (i = 0; i < `TAPS; i = i + 1) begin
         act_coef[i] = coef_ext(active_bank_o ? bank1[i] : bank0[i],
                                coef_width_i);
      end
   end

   // host writes and reads only ever touch the inactive bank
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (k_bank = 0; k_bank < `TAPS; k_bank = k_bank + 1) begin
            bank0[k_bank] <= 16'h0000;
            bank1[k_bank] <= 16'h0000;
         end
         coef_rdata_o <= 16'h0000;
      end else begin
         if (coef_wr_i && active_bank_o)
            bank0[coef_addr_i] <= coef_wdata_i;
         if (coef_wr_i && !active_bank_o)
            bank1[coef_addr_i] <= coef_wdata_i;
         if (coef_rd_i)
            coef_rdata_o <= active_bank_o ? bank0[coef_addr_i] :
                            bank1[coef_addr_i];
      end
   end

   // a swap request waits for the next sample edge, so the taps of one sample
   // never mix coefficients from both banks; a request in that cycle is kept
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         active_bank_o <= 1'b0;
         swap_pending_o <= 1'b0;
      end else begin
         if (samp_evt) begin
            if (swap_pending_o || cont_swap_i)
               active_bank_o <= ~active_bank_o;
            swap_pending_o <= bank_swap_i;
         end else if (bank_swap_i) begin
            swap_pending_o <= 1'b1;
         end
      end
   end

   // delay-and-add chain at full width; each tap sees the common sample
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (k_part = 0; k_part < `TAPS; k_part = k_part + 1)
            part[k_part] <= 36'h000000000;
      end else if (samp_evt) begin
         part[0] <= mac_term(samp_x, act_coef[0]);
         for (k_part = 1; k_part < `TAPS; k_part = k_part + 1)
            part[k_part] <= part[k_part-1] +
               mac_term(samp_x, act_coef[k_part]);
      end
   end

   // cascade line shifts once per sample; the word leaving the end
   // entered 32 samples ago
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (k_line = 0; k_line < `TAPS; k_line = k_line + 1)
            casc[k_line] <= 24'h000000;
         casc_tail <= 24'h000000;
         calc <= 1'b0;
      end else begin
         calc <= samp_evt;
         if (samp_evt) begin
            casc[0] <= casc_s2;
            for (k_line = 1; k_line < `TAPS; k_line = k_line + 1)
               casc[k_line] <= casc[k_line-1];
            casc_tail <= casc[`TAPS-1];
         end
      end
   end

   shift_round u_shift (
      .acc_i(part[`TAPS-1]),
      .shift_i(shift_i),
      .win_o(scaled)
   );

   // result one cycle after the sample edge; ready stays until host read,
   // and a new result beats a read in the same cycle
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         result_o <= 24'h000000;
         result_valid_o <= 1'b0;
         result_ready_o <= 1'b0;
      end else begin
         result_valid_o <= calc;
         if (calc) begin
            result_o <= scaled + casc_tail;
            result_ready_o <= 1'b1;
         end else if (host_result_rd_i) begin
            result_ready_o <= 1'b0;
         end
      end
   end

   // samples closer than the width's least spacing are still processed,
   // but flag an overrun so the host can see the source ran too fast
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap_cnt <= 8'hff;
         overrun_o <= 1'b0;
      end else begin
         if (samp_evt)
            gap_cnt <= 8'h00;
         else if (gap_cnt != 8'hff)
            gap_cnt <= gap_cnt + 8'h01;
         if (samp_evt && (gap_cnt < min_space(coef_width_i) - 8'h01))
            overrun_o <= 1'b1;
         else if (overrun_clr_i)
            overrun_o <= 1'b0;
      end
   end

endmodule

// ### corr_assertions.sv
// Purpose: port checks of the correlator
// Assumes: one clock domain
// Notes: bound to the top module
`timescale 1ns/10ps
module corr_assertions (
   input wire sys_clk_i,
   input wire rst_i,
   input wire host_sample_wr_i,
   input wire host_result_rd_i,
   input wire coef_rd_i,
   input wire bank_swap_i,
   input wire overrun_clr_i,
   input wire [15:0] coef_rdata_o,
   input wire [23:0] result_o,
   input wire result_valid_o,
   input wire result_ready_o,
   input wire active_bank_o,
   input wire swap_pending_o,
   input wire overrun_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // results and status follow their causes
   a_host_answer: assert property (
      host_sample_wr_i |-> ##2 result_valid_o) else $error("no result");
   a_result_hold: assert property (
      !result_valid_o |-> $stable(result_o)) else $error("result moved");
   a_ready_set: assert property (
      result_valid_o |-> result_ready_o) else $error("ready low");
   a_ready_clear: assert property (
      host_result_rd_i && !host_sample_wr_i |=>
      !result_ready_o || result_valid_o) else $error("ready stuck");
   // bank roles only move with a sample
   a_bank_event: assert property (
      active_bank_o != $past(active_bank_o) |=> result_valid_o)
      else $error("bank moved off sample");
   a_swap_pend: assert property (
      bank_swap_i |=> swap_pending_o) else $error("swap lost");
   a_swap_done: assert property (
      $fell(swap_pending_o) |-> active_bank_o != $past(active_bank_o))
      else $error("swap not applied");
   a_overrun_kept: assert property (
      overrun_o && !overrun_clr_i |=> overrun_o) else $error("overrun lost");
   a_rdata_hold: assert property (
      !coef_rd_i |=> $stable(coef_rdata_o)) else $error("rdata moved");
endmodule
bind transversal_correlator corr_assertions chk_u (.sys_clk_i, .rst_i,
   .host_sample_wr_i, .host_result_rd_i, .coef_rd_i, .bank_swap_i,
   .overrun_clr_i, .coef_rdata_o, .result_o, .result_valid_o,
   .result_ready_o, .active_bank_o, .swap_pending_o, .overrun_o);

// ### host_model.sv
// Purpose: host processor side of the correlator
// Assumes: pulses launched on falling edges
// Notes: sample spacing kept by the caller
`timescale 1ns/10ps
module host_model (
   input wire sys_clk_i,
   output reg [15:0] sample_o,
   output reg sample_wr_o,
   output reg [4:0] addr_o,
   output reg [15:0] wdata_o,
   output reg wr_o,
   output reg rd_o,
   output reg [15:0] pin_sample_o,
   output reg pin_strobe_o,
   output reg [23:0] casc_o
);
   integer i;
   initial begin
      {sample_o, sample_wr_o, addr_o, wdata_o, wr_o, rd_o} = 0;
      {pin_sample_o, pin_strobe_o, casc_o} = 0;
   end
   // one-cycle access to the inactive bank
   task coef(input [4:0] a, input [15:0] d, input r);
      begin
         @(negedge sys_clk_i);
         addr_o = a;
         wdata_o = d;
         wr_o = !r;
         rd_o = r;
         @(negedge sys_clk_i);
         wr_o = 0;
         rd_o = 0;
      end
   endtask
   // last reference value in tap 31, unused taps zeroed
   task load_ref(input [15:0] last);
      for (i = 0; i < 32; i = i + 1)
         coef(i[4:0], (i == 31) ? last : 16'h0000, 1'b0);
   endtask
   // convolution runs the other way: first reference value in tap 31
   task load_conv(input [15:0] r0, input [15:0] r1);
      for (i = 0; i < 32; i = i + 1)
         coef(i[4:0], (i == 31) ? r0 : (i == 30) ? r1 : 16'h0000, 1'b0);
   endtask
   // pin-side sample plus the word a prior device in the chain would
   // present; strobe held three cycles so the synchroniser sees it
   task pin(input [15:0] x, input [23:0] c);
      begin
         @(negedge sys_clk_i);
         pin_sample_o = x;
         casc_o = c;
         pin_strobe_o = 1;
         repeat (3) @(negedge sys_clk_i);
         pin_strobe_o = 0;
      end
   endtask
   task sample(input [15:0] x);
      begin
         @(negedge sys_clk_i);
         sample_o = x;
         sample_wr_o = 1;
         @(negedge sys_clk_i);
         sample_wr_o = 0;
      end
   endtask
endmodule

// ### tb_top.sv
// Purpose: self-checking bench of the correlator
// Assumes: host model drives the host sample and coefficient ports
// Notes: pin and cascade inputs come from the host model as well
`timescale 1ns/10ps
`define CHK(a,b) begin total_checks++; if ((a) !== (b)) begin fails++; \
   $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_top;
   reg sys_clk_i = 0;
   reg rst_i = 1;
   reg rd = 0, swp = 0, cont = 0, clr = 0;
   reg [1:0] cw = 2'h3;
   reg [3:0] sh = 4'h0;
   wire [15:0] hs, wd, rdat;
   wire [4:0] ad;
   wire hw, cwr, crd, vld, rdy, bank, pend, ovr;
   wire [23:0] res;
   wire [15:0] ps;
   wire pst;
   wire [23:0] cin;
   reg [23:0] want;
   integer k;
   integer fails = 0, total_checks = 0, cyc = 0;
   always #2 sys_clk_i = ~sys_clk_i;
   host_model host_u (.sys_clk_i, .sample_o(hs), .sample_wr_o(hw),
      .addr_o(ad), .wdata_o(wd), .wr_o(cwr), .rd_o(crd),
      .pin_sample_o(ps), .pin_strobe_o(pst), .casc_o(cin));
   transversal_correlator dut_u (.sys_clk_i, .rst_i,
      .pin_sample_i(ps), .pin_strobe_i(pst), .casc_in_i(cin),
      .host_sample_i(hs), .host_sample_wr_i(hw), .host_result_rd_i(rd),
      .coef_addr_i(ad), .coef_wdata_i(wd), .coef_wr_i(cwr),
      .coef_rd_i(crd), .coef_rdata_o(rdat), .bank_swap_i(swp),
      .cont_swap_i(cont), .coef_width_i(cw), .shift_i(sh),
      .overrun_clr_i(clr), .result_o(res), .result_valid_o(vld),
      .result_ready_o(rdy), .active_bank_o(bank), .swap_pending_o(pend),
      .overrun_o(ovr));
   // one sample, its result, then the least 16-bit spacing
   task smp(input [15:0] x, input [23:0] e);
      begin
         host_u.sample(x);
         @(negedge sys_clk_i);
         `CHK(vld, 1'b1)
         `CHK(rdy, 1'b1)
         `CHK(res, e)
         repeat (100) @(negedge sys_clk_i);
      end
   endtask
   task pulse_swap;
      begin
         swp = 1;
         @(negedge sys_clk_i);
         swp = 0;
      end
   endtask
   task t_swap;
      begin
         host_u.load_ref(16'h0001);
         host_u.coef(5'h1f, 16'h0000, 1'b1);
         `CHK(rdat, 16'h0001)
         pulse_swap;
         `CHK(pend, 1'b1)
         smp(16'h0007, 24'h0);
         `CHK({bank, pend}, 2'b10)
         smp(16'h0007, 24'h7);
      end
   endtask
   task t_round;
      begin
         sh = 4'h2;
         smp(16'h0007, 24'h2);
         sh = 4'h0;
         smp(16'hffff, 24'hffffff);
         rd = 1;
         @(negedge sys_clk_i);
         rd = 0;
         `CHK(rdy, 1'b0)
      end
   endtask
   // auto alternation: bank 1 holds +1, bank 0 holds a 4-bit -1
   task t_cont;
      begin
         host_u.load_ref(16'h000f);
         cw = 2'h0;
         cont = 1;
         smp(16'h0003, 24'h3);
         smp(16'h0003, 24'hfffffd);
         cont = 0;
         cw = 2'h3;
      end
   endtask
   task t_overrun;
      begin
         host_u.sample(16'h0001);
         host_u.sample(16'h0001);
         `CHK(ovr, 1'b1)
         clr = 1;
         @(negedge sys_clk_i);
         clr = 0;
         `CHK(ovr, 1'b0)
      end
   endtask
   // pin path at the 4-bit rate; a cascade word shows 32 samples later
   task t_casc;
      begin
         repeat (30) @(negedge sys_clk_i);
         cw = 2'h0;
         for (k = 0; k < 33; k = k + 1) begin
            host_u.pin(k[15:0], (k == 0) ? 24'h123456 : 24'h0);
            @(negedge sys_clk_i);
            want = k[23:0] + ((k == 32) ? 24'h123456 : 24'h0);
            `CHK(vld, 1'b1)
            `CHK(res, want)
            repeat (24) @(negedge sys_clk_i);
         end
         `CHK(ovr, 1'b0)
         cw = 2'h3;
      end
   endtask
   // reversed load of reference 1, 2 gives y0*x0, then y0*x1
   task t_conv;
      begin
         host_u.load_conv(16'h0001, 16'h0002);
         pulse_swap;
         smp(16'h0000, 24'h0);
         smp(16'h0003, 24'h3);
         smp(16'h0000, 24'h6);
      end
   endtask
   task summarize;
      begin
         $display("checks %0d fails %0d", total_checks, fails);
         if (fails == 0 && total_checks > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // cut a hang short
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         summarize;
      end
   end
   initial begin
      repeat (12) @(negedge sys_clk_i);
      rst_i = 0;
      `CHK({res, vld, rdy, bank, pend, ovr}, 29'h0)
      t_swap;
      t_round;
      t_cont;
      t_overrun;
      t_casc;
      t_conv;
      summarize;
   end
endmodule
